// [dv/tb.sv]
// self-checking bench for the pump, calibration and detector configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [23:0] cal;
        logic [8:0] cyc;
        logic [5:0] per;
        logic [7:0] curve;
    } row_type;
    // calibration word beside decoded cycles, tick period and expected curve
    row_type rows [8] = '{'{24'h000000, 9'h001, 6'h01, 8'h3C}, '{24'h002401, 9'h002, 6'h04, 8'hA5},
        '{24'h004002, 9'h004, 6'h10, 8'h3C}, '{24'h006403, 9'h008, 6'h20, 8'hA5},
        '{24'h000404, 9'h020, 6'h01, 8'hA5}, '{24'h002005, 9'h040, 6'h04, 8'h3C},
        '{24'h004C06, 9'h080, 6'h10, 8'hA5}, '{24'h006007, 9'h100, 6'h20, 8'h3C}};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic [7:0] search_curve = 8'h3C;
    logic [7:0] tuning_curve = 8'hA5;
    logic detector_up_pin = 1'b0;
    logic detector_down_pin = 1'b0;
    logic [15:0] phase_error_ps = 16'h0000;
    logic [23:0] reg_rdata, w;
    logic [6:0] pump_down_gain, pump_up_gain, leak_magnitude;
    logic leak_up_enable, leak_down_enable, curve_forced, bypass_tuning;
    logic internal_vco_link_start, cal_fsm_tick, pump_up_drive, pump_down_drive, slip_boost;
    logic [8:0] tune_resolution_cycles;
    logic [7:0] applied_curve;
    logic [2:0] detector_reset_delay;
    logic [15:0] thr;
    int bad_count = 0;
    int n_compared = 0;
    int n;

    pll_pump_detector_config DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pump_down_gain(pump_down_gain), .pump_up_gain(pump_up_gain),
        .leak_magnitude(leak_magnitude), .leak_up_enable(leak_up_enable),
        .leak_down_enable(leak_down_enable), .search_curve(search_curve),
        .tuning_curve(tuning_curve), .tune_resolution_cycles(tune_resolution_cycles),
        .applied_curve(applied_curve), .curve_forced(curve_forced),
        .bypass_tuning(bypass_tuning), .internal_vco_link_start(internal_vco_link_start),
        .cal_fsm_tick(cal_fsm_tick), .detector_up_pin(detector_up_pin),
        .detector_down_pin(detector_down_pin), .phase_error_ps(phase_error_ps),
        .detector_reset_delay(detector_reset_delay), .pump_up_drive(pump_up_drive),
        .pump_down_drive(pump_down_drive), .slip_boost(slip_boost));

    // 50 ns period
    always #25 core_clk = ~core_clk;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t ns %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    // inputs move 5 ns after the edge so the sampling edge never races them
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #5;
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
    endtask

    // readback lags the address by one edge, so two edges are allowed
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        reg_addr = a;
        step(2);
        check(reg_rdata, exp, "readback");
    endtask

    // the bound covers two periods of the slowest ratio; the counter never wraps after a ratio change
    task automatic wait_tick();
        n = 0;
        do begin
            step(1);
            n++;
        end while (cal_fsm_tick !== 1'b1 && n < 80);
        if (n == 80) begin
            bad_count++;
            $display("[FAIL] %0t ns tick wait ran out", $time);
            end_of_test();
        end
    endtask

    task automatic link_pulses(input int exp);
        reg_addr = 6'h05;
        reg_wr = 1'b1;
        n = 0;
        for (int i = 0; i < 5; i++) begin
            step(1);
            if (i == 1) reg_wr = 1'b0;
            n += int'(internal_vco_link_start === 1'b1);
        end
        check(24'(n), 24'(exp), "link pulses");
    endtask

    task automatic pump_case(input logic [23:0] d, input logic up, input logic dn,
        input logic eu, input logic ed);
        wr(6'h0B, d);
        detector_up_pin = up;
        detector_down_pin = dn;
        step(4);
        check(24'(pump_up_drive), 24'(eu), "up drive");
        check(24'(pump_down_drive), 24'(ed), "down drive");
    endtask

    initial begin
        repeat (11) @(posedge core_clk);
        #5;
        check(reg_rdata, 24'h000000, "rdata in reset");
        step(1);
        rst_n = 1'b1;
        // values after reset
        rd(6'h09, pll_cfg_pkg::PUMP_RESET);
        rd(6'h0A, pll_cfg_pkg::CAL_RESET);
        rd(6'h0B, pll_cfg_pkg::DET_RESET);
        rd(6'h0C, 24'h000000);
        check(24'(pump_down_gain), 24'h000064, "down gain");
        check(24'(pump_up_gain), 24'h000064, "up gain");
        check(24'(leak_magnitude), 24'h000000, "leak");
        check(24'({leak_down_enable, leak_up_enable}), 24'h000002, "leak dirs");
        check(24'(detector_reset_delay), 24'h000001, "delay");
        check(24'(tune_resolution_cycles), 24'h000040, "cycles");
        $display("test reset done");
        // ordinary cases: resolution, curve forcing and calibration clock
        foreach (rows[i]) begin
            wr(6'h0A, rows[i].cal);
            rd(6'h0A, rows[i].cal);
            check(24'(tune_resolution_cycles), 24'(rows[i].cyc), "cycles");
            check(24'(applied_curve), 24'(rows[i].curve), "curve");
            check(24'(curve_forced), 24'(rows[i].cal[10]), "forced");
            check(24'(bypass_tuning), 24'(rows[i].cal[11]), "bypass");
            wait_tick();
            wait_tick();
            wait_tick();
            check(24'(n), 24'(rows[i].per), "tick period");
        end
        $display("test calibration table done");
        // pump fields at their extremes, reserved bit stored
        for (int i = 0; i < 2; i++) begin
            w = (i == 0) ? 24'h3FC07F : 24'hC03F80;
            wr(6'h09, w);
            rd(6'h09, w);
            check(24'(pump_down_gain), 24'(w[6:0]), "down gain");
            check(24'(pump_up_gain), 24'(w[13:7]), "up gain");
            check(24'(leak_magnitude), 24'(w[20:14]), "leak");
            check(24'({leak_down_enable, leak_up_enable}), 24'(w[22:21]), "dirs");
        end
        $display("test pump fields done");
        // back-to-back transfers, then suppressed
        link_pulses(2);
        wr(6'h0A, 24'h001000);
        // one idle edge so the strobe is not lowered and raised in one time step
        step(1);
        link_pulses(0);
        $display("test vco transfer done");
        // enables block, forces win over a cleared enable
        pump_case(24'h0F8061, 1'b1, 1'b0, 1'b1, 1'b0);
        pump_case(24'h0F8061, 1'b0, 1'b1, 1'b0, 1'b1);
        pump_case(24'h0F8041, 1'b1, 1'b1, 1'b0, 1'b1);
        pump_case(24'h0F8021, 1'b1, 1'b1, 1'b1, 1'b0);
        pump_case(24'h0F8601, 1'b0, 1'b0, 1'b1, 1'b1);
        $display("test pump drive done");
        // slip threshold: equal stays quiet, one ps more boosts in modes 1 to 3 and stays quiet in mode 0
        for (int m = 0; m < 4; m++) begin
            thr = (m == 1) ? pll_cfg_pkg::SLIP_THR1_PS : (m == 2) ? pll_cfg_pkg::SLIP_THR2_PS :
                (m == 3) ? pll_cfg_pkg::SLIP_THR3_PS : 16'hFFFE;
            wr(6'h0B, pll_cfg_pkg::DET_RESET | (24'(m) << 7));
            phase_error_ps = thr;
            step(2);
            check(24'(slip_boost), 24'h000000, "slip at threshold");
            phase_error_ps = thr + 16'h0001;
            step(2);
            check(24'(slip_boost), 24'(m != 0), "slip above");
        end
        $display("test slip done");
        // asynchronous reset in mid-run restores every register at once
        rst_n = 1'b0;
        step(1);
        check(reg_rdata, 24'h000000, "rdata in second reset");
        check(24'(slip_boost), 24'h000000, "slip in reset");
        check(24'(pump_down_gain), 24'h000064, "down gain in reset");
        rst_n = 1'b1;
        rd(6'h0B, pll_cfg_pkg::DET_RESET);
        rd(6'h0A, pll_cfg_pkg::CAL_RESET);
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire

// [src/pll_cfg_pkg.sv]
// constants for the pump, calibration and detector configuration bank
package pll_cfg_pkg;
    // register offsets on the internal register port
    localparam logic [5:0] VCO_TUNE_OFFSET = 6'h05;
    localparam logic [5:0] PUMP_OFFSET = 6'h09;
    localparam logic [5:0] CAL_OFFSET = 6'h0A;
    localparam logic [5:0] DET_OFFSET = 6'h0B;
    localparam int REG_WIDTH = 24;
    // values after reset
    localparam logic [23:0] PUMP_RESET = 24'h403264;
    localparam logic [23:0] CAL_RESET = 24'h002205;
    localparam logic [23:0] DET_RESET = 24'h0F8061;
    // pump register fields
    localparam int DOWN_GAIN_LSB = 0;
    localparam int UP_GAIN_LSB = 7;
    localparam int LEAK_MAG_LSB = 14;
    localparam int LEAK_UP_BIT = 21;
    localparam int LEAK_DOWN_BIT = 22;
    localparam int GAIN_WIDTH = 7;
    // calibration register fields
    localparam int RES_LSB = 0;
    localparam int FORCE_CURVE_BIT = 10;
    localparam int BYPASS_TUNE_BIT = 11;
    localparam int NO_LINK_TRIG_BIT = 12;
    localparam int FSM_CLK_LSB = 13;
    // detector register fields
    localparam int DELAY_LSB = 0;
    localparam int UP_EN_BIT = 5;
    localparam int DOWN_EN_BIT = 6;
    localparam int SLIP_LSB = 7;
    localparam int FORCE_UP_BIT = 9;
    localparam int FORCE_DOWN_BIT = 10;
    // slip prevention thresholds in picoseconds
    localparam logic [15:0] SLIP_THR1_PS = 16'h1518; // 5.4 ns
    localparam logic [15:0] SLIP_THR2_PS = 16'h3840; // 14.4 ns
    localparam logic [15:0] SLIP_THR3_PS = 16'h5E24; // 24.1 ns
    // calibration clock division ratios for codes 0..3
    localparam logic [5:0] FSM_DIV0 = 6'h01;
    localparam logic [5:0] FSM_DIV1 = 6'h04;
    localparam logic [5:0] FSM_DIV2 = 6'h10;
    localparam logic [5:0] FSM_DIV3 = 6'h20;
    localparam int FSM_CLK_MAX_MHZ = 50;
    localparam int CORE_CLK_MHZ = 20;
endpackage

// [src/pll_pump_detector_config.sv]
// configuration bank for charge pump, vco calibration and phase detector
`timescale 1ns/1ps
`default_nettype none
module pll_pump_detector_config #(
    parameter int CURVE_WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port from the serial programming core
    input wire logic reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    // charge pump settings
    output logic [6:0] pump_down_gain,
    output logic [6:0] pump_up_gain,
    output logic [6:0] leak_magnitude,
    output logic leak_up_enable,
    output logic leak_down_enable,
    // vco calibration
    input wire logic [CURVE_WIDTH-1:0] search_curve,
    input wire logic [CURVE_WIDTH-1:0] tuning_curve,
    output logic [8:0] tune_resolution_cycles,
    output logic [CURVE_WIDTH-1:0] applied_curve,
    output logic curve_forced,
    output logic bypass_tuning,
    output logic internal_vco_link_start,
    output logic cal_fsm_tick,
    // phase detector and pump drive
    input wire logic detector_up_pin,
    input wire logic detector_down_pin,
    input wire logic [15:0] phase_error_ps,
    output logic [2:0] detector_reset_delay,
    output logic pump_up_drive,
    output logic pump_down_drive,
    output logic slip_boost
);
    logic [23:0] pump_ff;
    logic [23:0] cal_ff;
    logic [23:0] det_ff;
    logic [23:0] rdata_ff;
    logic link_start_ff;
    logic [5:0] div_cnt_ff;
    logic tick_ff;
    logic [1:0] up_sync_ff;
    logic [1:0] down_sync_ff;
    logic up_drive_ff;
    logic down_drive_ff;
    logic slip_ff;
    logic [CURVE_WIDTH-1:0] curve_ff;
    logic [8:0] res_ff;
    logic [5:0] nxt_div_ratio;
    logic [8:0] nxt_res;
    logic [15:0] nxt_thr;
    logic [2:0] res_code;
    logic [1:0] fsm_code;
    logic [1:0] slip_code;

    assign res_code = cal_ff[pll_cfg_pkg::RES_LSB +: 3];
    assign fsm_code = cal_ff[pll_cfg_pkg::FSM_CLK_LSB +: 2];
    assign slip_code = det_ff[pll_cfg_pkg::SLIP_LSB +: 2];

    // register writes; reserved bits are kept as written so readback is faithful
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_ff <= pll_cfg_pkg::PUMP_RESET;
            cal_ff <= pll_cfg_pkg::CAL_RESET;
            det_ff <= pll_cfg_pkg::DET_RESET;
        end else if (reg_wr) begin
            if (reg_addr == pll_cfg_pkg::PUMP_OFFSET) begin
                pump_ff <= reg_wdata;
            end
            if (reg_addr == pll_cfg_pkg::CAL_OFFSET) begin
                cal_ff <= reg_wdata;
            end
            if (reg_addr == pll_cfg_pkg::DET_OFFSET) begin
                det_ff <= reg_wdata;
            end
        end
    end

    // readback one cycle after the address; unmapped offsets read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 24'h000000;
        end else begin
            unique case (reg_addr)
                pll_cfg_pkg::PUMP_OFFSET: rdata_ff <= pump_ff;
                pll_cfg_pkg::CAL_OFFSET: rdata_ff <= cal_ff;
                pll_cfg_pkg::DET_OFFSET: rdata_ff <= det_ff;
                default: rdata_ff <= 24'h000000;
            endcase
        end
    end

    // pump and detector fields straight from the registers
    assign pump_down_gain = pump_ff[pll_cfg_pkg::DOWN_GAIN_LSB +: 7];
    assign pump_up_gain = pump_ff[pll_cfg_pkg::UP_GAIN_LSB +: 7];
    assign leak_magnitude = pump_ff[pll_cfg_pkg::LEAK_MAG_LSB +: 7];
    assign leak_up_enable = pump_ff[pll_cfg_pkg::LEAK_UP_BIT];
    assign leak_down_enable = pump_ff[pll_cfg_pkg::LEAK_DOWN_BIT];
    assign detector_reset_delay = det_ff[pll_cfg_pkg::DELAY_LSB +: 3];
    assign reg_rdata = rdata_ff;
    assign curve_forced = cal_ff[pll_cfg_pkg::FORCE_CURVE_BIT];
    assign bypass_tuning = cal_ff[pll_cfg_pkg::BYPASS_TUNE_BIT];
    assign tune_resolution_cycles = res_ff;
    assign applied_curve = curve_ff;
    assign internal_vco_link_start = link_start_ff;
    assign cal_fsm_tick = tick_ff;
    assign pump_up_drive = up_drive_ff;
    assign pump_down_drive = down_drive_ff;
    assign slip_boost = slip_ff;

    // resolution decode and slip threshold select
    always_comb begin
        unique case (res_code)
            3'h0: nxt_res = 9'h001;
            3'h1: nxt_res = 9'h002;
            3'h2: nxt_res = 9'h004;
            3'h3: nxt_res = 9'h008;
            3'h4: nxt_res = 9'h020; // code 4 jumps to 32, not 16
            3'h5: nxt_res = 9'h040;
            3'h6: nxt_res = 9'h080;
            default: nxt_res = 9'h100;
        endcase
        unique case (fsm_code)
            2'h0: nxt_div_ratio = pll_cfg_pkg::FSM_DIV0;
            2'h1: nxt_div_ratio = pll_cfg_pkg::FSM_DIV1;
            2'h2: nxt_div_ratio = pll_cfg_pkg::FSM_DIV2;
            default: nxt_div_ratio = pll_cfg_pkg::FSM_DIV3;
        endcase
        unique case (slip_code)
            2'h1: nxt_thr = pll_cfg_pkg::SLIP_THR1_PS;
            2'h2: nxt_thr = pll_cfg_pkg::SLIP_THR2_PS;
            default: nxt_thr = pll_cfg_pkg::SLIP_THR3_PS;
        endcase
    end

    // calibration datapath: resolution count and curve selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_ff <= 9'h040;
            curve_ff <= '0;
        end else begin
            res_ff <= nxt_res;
            curve_ff <= curve_forced ? tuning_curve : search_curve;
        end
    end

    // transfer to the vco side on a write to the tuning register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_start_ff <= 1'b0;
        end else begin
            link_start_ff <= reg_wr && (reg_addr == pll_cfg_pkg::VCO_TUNE_OFFSET)
                && !cal_ff[pll_cfg_pkg::NO_LINK_TRIG_BIT];
        end
    end

    // calibration clock enable; core clock is the reference, well under the limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end else if (div_cnt_ff >= nxt_div_ratio - 6'h01) begin
            div_cnt_ff <= 6'h00; // also recovers when the ratio shrinks
            tick_ff <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 6'h01;
            tick_ff <= 1'b0;
        end
    end

    // detector pulses come from another domain: two flops before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_sync_ff <= 2'b00;
            down_sync_ff <= 2'b00;
        end else begin
            up_sync_ff <= {up_sync_ff[0], detector_up_pin};
            down_sync_ff <= {down_sync_ff[0], detector_down_pin};
        end
    end

    // pump drive: force bits override, enables gate the detector
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_drive_ff <= 1'b0;
            down_drive_ff <= 1'b0;
        end else begin
            up_drive_ff <= det_ff[pll_cfg_pkg::FORCE_UP_BIT]
                || (up_sync_ff[1] && det_ff[pll_cfg_pkg::UP_EN_BIT]);
            down_drive_ff <= det_ff[pll_cfg_pkg::FORCE_DOWN_BIT]
                || (down_sync_ff[1] && det_ff[pll_cfg_pkg::DOWN_EN_BIT]);
        end
    end

    // cycle slip boost when the phase error passes the chosen threshold
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_ff <= 1'b0;
        end else begin
            slip_ff <= (slip_code != 2'h0) && (phase_error_ps > nxt_thr);
        end
    end

    // helpers for the checks below
    logic [6:0] wr_down_field;
    logic [6:0] wr_up_field;
    logic [6:0] wr_leak_field;
    logic wr_pump;
    assign wr_down_field = reg_wdata[6:0];
    assign wr_up_field = reg_wdata[13:7];
    assign wr_leak_field = reg_wdata[20:14];
    assign wr_pump = reg_wr && (reg_addr == pll_cfg_pkg::PUMP_OFFSET);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_down_gain_load: assert property (wr_pump |=> pump_down_gain == $past(wr_down_field))
        else $error("down gain not loaded from write");
    a_up_gain_load: assert property (wr_pump |=> pump_up_gain == $past(wr_up_field))
        else $error("up gain not loaded from write");
    a_leak_mag_load: assert property (wr_pump |=> leak_magnitude == $past(wr_leak_field))
        else $error("leak magnitude not loaded from write");
    a_res_decode_map: assert property (res_code == 3'h4 ##1 res_code == 3'h4 |-> tune_resolution_cycles == 9'h020)
        else $error("resolution code 4 not decoded to 32");
    a_curve_force_sel: assert property (curve_forced |=> applied_curve == $past(tuning_curve))
        else $error("forced curve not applied");
    a_link_trig_gate: assert property (reg_wr && reg_addr == 6'h05 |=> internal_vco_link_start == !$past(cal_ff[12]))
        else $error("vco transfer trigger wrong");
    // the ratio must stay at four over the whole gap, or a rewrite in mid-period trips it
    a_tick_div_four: assert property (fsm_code == 2'h1 && cal_fsm_tick
        ##1 fsm_code == 2'h1 ##1 fsm_code == 2'h1 ##1 fsm_code == 2'h1
        |-> !cal_fsm_tick && !$past(cal_fsm_tick) && !$past(cal_fsm_tick, 2) ##1 cal_fsm_tick)
        else $error("calibration tick spacing wrong for divide by four");
    a_up_force_drive: assert property (det_ff[9] |=> pump_up_drive)
        else $error("forced pump up not driven");
    a_down_force_drive: assert property (det_ff[10] |=> pump_down_drive)
        else $error("forced pump down not driven");
    a_up_enable_gate: assert property (!det_ff[5] && !det_ff[9] |=> !pump_up_drive)
        else $error("up pulse passed while disabled");
    a_down_enable_gate: assert property (!det_ff[6] && !det_ff[10] |=> !pump_down_drive)
        else $error("down pulse passed while disabled");
    a_slip_off_mode: assert property (slip_code == 2'h0 |=> !slip_boost)
        else $error("slip boost while disabled");

    c_link_start: cover property (internal_vco_link_start);
    c_slip_boost: cover property (slip_boost);
    c_up_pulse: cover property (pump_up_drive && !det_ff[9]);
endmodule
`default_nettype wire
